/* File: hdl/sdram_timing_params.svh */
// register map, field positions, reset values and timing limits of the area 3 timing block
`ifndef SDRAM_TIMING_PARAMS_SVH
`define SDRAM_TIMING_PARAMS_SVH

// register offsets (byte addresses on the register port)
`define WAIT_CTRL_OFFSET      8'h00
`define STATUS_OFFSET         8'h04

// wait control field positions (low bit of each two-bit field)
`define PRECHARGE_WAIT_POS    13
`define ACT_ACCESS_WAIT_POS   10
`define CAS_LATENCY_POS       7
`define WRITE_RECOVERY_POS    3

// wait control reset value and mask of the writable bits
`define WAIT_CTRL_RESET       32'h0000_0500
`define WAIT_CTRL_WMASK       32'h0000_6D98

// status layout: open banks in the low bits, then the self-refresh flag and the precharge-all busy flag
`define STATUS_OPEN_POS       0
`define STATUS_SELF_POS       8
`define STATUS_PRECHARGE_ALL_CMD_BUSY_POS  9

// depth of the read latency pipeline, longest cas latency in cycles
`define CAS_MAX_CYCLES        3

`endif

/* File: hdl/sdram_timing_pkg.sv */
// types shared by the area 3 command timing block
package sdram_timing_pkg;

	typedef enum logic [3:0] {
		cmd_nop,
		activate_cmd,
		read_cmd,
		read_autoprecharge_cmd,
		plain_write_cmd,
		write_autoprecharge_cmd,
		precharge_cmd,
		precharge_all_cmd,
		auto_refresh_cmd,
		self_refresh_cmd,
		self_refresh_exit_cmd
	} sdram_op_t;

	typedef struct packed {
		sdram_op_t  op;
		logic [1:0] bank;
	} sdram_cmd_t;

	typedef enum logic [0:0] {
		st_normal,
		st_self_refresh
	} power_state_t;

endpackage

/* File: hdl/gap_counter.sv */
// down-counter that holds off a dependent command for a programmed number of cycles
`timescale 1ns/1ps
module gap_counter #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// load and status
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired
);

	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	// a load wins over the running count so a fresh command always restarts the gap
	always_comb begin
		nxt_count = count_ff;
		if (load) begin
			nxt_count = load_val;
		end else if (count_ff != '0) begin
			nxt_count = count_ff - W'(1);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign expired = (count_ff == '0);

endmodule

/* File: hdl/cas_pipe.sv */
// read latency pipeline: marks the cycle in which read data is due from the memory
`timescale 1ns/1ps
module cas_pipe #(
	parameter int DEPTH = 3
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// read issue and latency in cycles (1..DEPTH)
	input  wire logic       rd_issue,
	input  wire logic [1:0] latency,
	output logic            rd_due
);

	logic [DEPTH-1:0] pipe_ff;
	logic [DEPTH-1:0] nxt_pipe;

	// the read enters at the stage that leaves exactly latency cycles to the output
	always_comb begin
		nxt_pipe = {1'b0, pipe_ff[DEPTH-1:1]};
		for (int i = 0; i < DEPTH; i++) begin
			if (rd_issue && (int'(latency) == i + 1)) begin
				nxt_pipe[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pipe_ff <= '0;
		end else begin
			pipe_ff <= nxt_pipe;
		end
	end

	assign rd_due = pipe_ff[0];

endmodule

/* File: hdl/sdram_area3_cmd_timing.sv */
// area 3 sdram command timing: wait control register and command gap enforcement
//
// Contract
// RQ1: precharge wait codes give 0..3 inserted cycles
// RQ2: precharge wait before activate to same bank
// RQ3: precharge wait from precharge-all to refresh/self-refresh
// RQ4: activate-to-access wait 0..3, reset code 01
// RQ5: cas latency 1/2/3 cycles, code 11 reserved
// RQ6: write recovery before auto-precharge starts
// RQ7: write recovery after write before precharge
// RQ8: write recovery codes give 0..3 cycles
// RQ9: reserved bits read zero, software writes zero
// RQ10: software sets write recovery to memory need
// RQ11: down-counters, nop until expiry, then command
`timescale 1ns/1ps
`include "sdram_timing_params.svh"
module sdram_area3_cmd_timing
	import sdram_timing_pkg::*;
#(
	parameter int BANKS = 4
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [31:0]      reg_rdata,
	// command requests from the bus-state sequencer
	input  wire logic             req_valid,
	input  wire sdram_cmd_t       req_cmd,
	output logic                  req_ack,
	// commands towards the memory pins and read data timing
	output sdram_cmd_t            mem_cmd,
	output logic                  rd_data_due
);

	localparam int CW = 3;

	////////////////////////////////////////////////////////////////////////////////
	// field decoders

	// two-bit wait code to cycle count, shared by the three wait fields
	function automatic logic [CW-1:0] wait_cycles(input logic [1:0] code);
		wait_cycles = {1'b0, code}; // RQ1 RQ4 RQ8
	endfunction

	// reserved latency code falls back to the longest latency rather than a short one
	function automatic logic [1:0] cas_cycles(input logic [1:0] code);
		case (code)
			2'h0:    cas_cycles = 2'h1;
			2'h1:    cas_cycles = 2'h2;
			2'h2:    cas_cycles = 2'h3;
			default: cas_cycles = 2'h3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// wait control register

	logic [31:0]   ctrl_ff;
	logic [31:0]   nxt_ctrl;
	logic [CW-1:0] trp;
	logic [CW-1:0] trcd;
	logic [CW-1:0] write_recovery;
	logic [1:0]    cas_lat;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (reg_wr && (reg_addr == `WAIT_CTRL_OFFSET)) begin
			nxt_ctrl = reg_wdata & `WAIT_CTRL_WMASK; // RQ9
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= `WAIT_CTRL_RESET; // RQ4 RQ5
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	assign trp     = wait_cycles(ctrl_ff[`PRECHARGE_WAIT_POS +: 2]); // RQ1
	assign trcd    = wait_cycles(ctrl_ff[`ACT_ACCESS_WAIT_POS +: 2]); // RQ4
	assign write_recovery    = wait_cycles(ctrl_ff[`WRITE_RECOVERY_POS +: 2]); // RQ8
	assign cas_lat = cas_cycles(ctrl_ff[`CAS_LATENCY_POS +: 2]); // RQ5

	////////////////////////////////////////////////////////////////////////////////
	// gap counters: one set per bank plus one for the refresh sequences

	logic [BANKS-1:0]          pre_load;
	logic [BANKS-1:0]          act_load;
	logic [BANKS-1:0]          wr_load;
	logic [BANKS-1:0][CW-1:0]  pre_val;
	logic [BANKS-1:0]          pre_done;
	logic [BANKS-1:0]          act_done;
	logic [BANKS-1:0]          wr_done;
	logic                      precharge_all_cmd_load;
	logic                      precharge_all_cmd_done;

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : g_bank
			gap_counter #(.W(CW)) u_pre (
				.mclk     (mclk),
				.rst      (rst),
				.load     (pre_load[g]),
				.load_val (pre_val[g]),
				.expired  (pre_done[g])
			);
			gap_counter #(.W(CW)) u_act (
				.mclk     (mclk),
				.rst      (rst),
				.load     (act_load[g]),
				.load_val (trcd),
				.expired  (act_done[g])
			);
			gap_counter #(.W(CW)) u_wr (
				.mclk     (mclk),
				.rst      (rst),
				.load     (wr_load[g]),
				.load_val (write_recovery),
				.expired  (wr_done[g])
			);
		end
	endgenerate

	gap_counter #(.W(CW)) u_precharge_all_cmd (
		.mclk     (mclk),
		.rst      (rst),
		.load     (precharge_all_cmd_load),
		.load_val (trp),
		.expired  (precharge_all_cmd_done)
	);

	////////////////////////////////////////////////////////////////////////////////
	// command admission and issue

	sdram_cmd_t        cmd_ff;
	sdram_cmd_t        nxt_cmd;
	logic              ack_ff;
	logic              nxt_ack;
	power_state_t      state_ff;
	power_state_t      nxt_state;
	logic [BANKS-1:0]  open_ff;
	logic [BANKS-1:0]  nxt_open;
	logic              allowed;
	logic              take;
	logic              rd_issue;
	int unsigned       b;

	assign b = int'(req_cmd.bank);

	// a request stays up until its ack, so the ack cycle itself must not admit it twice
	always_comb begin
		allowed = 1'b0;
		case (state_ff)
			st_normal: begin
				case (req_cmd.op)
					activate_cmd: begin
						allowed = !open_ff[b] && pre_done[b]; // RQ2 RQ11
					end
					read_cmd, read_autoprecharge_cmd,
					plain_write_cmd, write_autoprecharge_cmd: begin
						allowed = open_ff[b] && act_done[b]; // RQ4 RQ11
					end
					precharge_cmd: begin
						allowed = wr_done[b]; // RQ7 RQ11
					end
					precharge_all_cmd: begin
						allowed = &wr_done; // RQ7
					end
					auto_refresh_cmd, self_refresh_cmd: begin
						allowed = precharge_all_cmd_done && (open_ff == '0); // RQ3 RQ11
					end
					default: begin
						allowed = 1'b0;
					end
				endcase
			end
			st_self_refresh: begin
				allowed = (req_cmd.op == self_refresh_exit_cmd);
			end
			default: begin
				allowed = 1'b0;
			end
		endcase
	end

	assign take     = req_valid && !ack_ff && allowed;
	assign rd_issue = take && (state_ff == st_normal) &&
		((req_cmd.op == read_cmd) || (req_cmd.op == read_autoprecharge_cmd));

	always_comb begin
		nxt_cmd   = '{op: cmd_nop, bank: 2'h0}; // RQ11
		nxt_ack   = take;
		nxt_state = state_ff;
		nxt_open  = open_ff;
		pre_load  = '0;
		act_load  = '0;
		wr_load   = '0;
		precharge_all_cmd_load = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			pre_val[i] = trp; // RQ2
		end
		if (take) begin
			nxt_cmd = req_cmd;
			case (req_cmd.op)
				activate_cmd: begin
					nxt_open[b] = 1'b1;
					act_load[b] = 1'b1; // RQ4
				end
				plain_write_cmd: begin
					wr_load[b] = 1'b1; // RQ7
				end
				write_autoprecharge_cmd: begin
					// auto-precharge starts after write recovery, then the bank needs precharge wait
					nxt_open[b] = 1'b0;
					pre_load[b] = 1'b1;
					pre_val[b]  = write_recovery + trp; // RQ6 RQ2
				end
				read_autoprecharge_cmd, precharge_cmd: begin
					nxt_open[b] = 1'b0;
					pre_load[b] = 1'b1; // RQ2
				end
				precharge_all_cmd: begin
					nxt_open  = '0;
					pre_load  = '1; // RQ2
					precharge_all_cmd_load = 1'b1; // RQ3
				end
				self_refresh_cmd: begin
					nxt_state = st_self_refresh;
				end
				self_refresh_exit_cmd: begin
					nxt_state = st_normal;
				end
				default: begin
					nxt_open = open_ff;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_ff   <= '{op: cmd_nop, bank: 2'h0};
			ack_ff   <= 1'b0;
			state_ff <= st_normal;
			open_ff  <= '0;
		end else begin
			cmd_ff   <= nxt_cmd;
			ack_ff   <= nxt_ack;
			state_ff <= nxt_state;
			open_ff  <= nxt_open;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read latency

	cas_pipe #(.DEPTH(`CAS_MAX_CYCLES)) u_cas (
		.mclk     (mclk),
		.rst      (rst),
		.rd_issue (rd_issue),
		.latency  (cas_lat), // RQ5
		.rd_due   (rd_data_due)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register read

	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] status_word;

	always_comb begin
		status_word = '0;
		status_word[`STATUS_OPEN_POS +: BANKS] = open_ff;
		status_word[`STATUS_SELF_POS]          = (state_ff == st_self_refresh);
		status_word[`STATUS_PRECHARGE_ALL_CMD_BUSY_POS]     = !precharge_all_cmd_done;
	end

	// data stands only in the cycle after the strobe; unmapped offsets read zero
	always_comb begin
		nxt_rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				`WAIT_CTRL_OFFSET: nxt_rdata = ctrl_ff & `WAIT_CTRL_WMASK; // RQ9
				`STATUS_OFFSET:    nxt_rdata = status_word;
				default:           nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign req_ack   = ack_ff;
	assign mem_cmd   = cmd_ff;

endmodule

/* File: verif/sdram_chip_model.sv */
// behavioural memory chip: open rows per bank, counts illegal commands
`timescale 1ns/1ps
module sdram_chip_model import sdram_timing_pkg::*; (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// command pins and fault count
	input  wire sdram_cmd_t mem_cmd,
	output logic [7:0]      faults
);
logic [3:0] open_ff, nxt_open;
logic [7:0] faults_ff, nxt_faults;
logic       bad;
logic [1:0] b;
assign b = mem_cmd.bank;
assign faults = faults_ff;
always_comb begin
	nxt_open = open_ff;
	bad = 1'b0;
	case (mem_cmd.op)
		activate_cmd: begin
			bad = open_ff[b];
			nxt_open[b] = 1'b1;
		end
		read_cmd, plain_write_cmd: bad = !open_ff[b];
		read_autoprecharge_cmd, write_autoprecharge_cmd: begin
			bad = !open_ff[b];
			nxt_open[b] = 1'b0;
		end
		precharge_cmd: nxt_open[b] = 1'b0;
		precharge_all_cmd: nxt_open = 4'h0;
		auto_refresh_cmd, self_refresh_cmd: bad = |open_ff;
		default: ;
	endcase
	nxt_faults = faults_ff + {7'h0, bad};
end
always_ff @(posedge mclk or posedge rst) begin
	if (rst) begin
		open_ff <= 4'h0;
		faults_ff <= 8'h0;
	end else begin
		open_ff <= nxt_open;
		faults_ff <= nxt_faults;
	end
end
endmodule

/* File: verif/sdram_area3_cmd_timing_sva.sv */
// port assertions for the area 3 command timing block
`timescale 1ns/1ps
module sdram_area3_cmd_timing_sva import sdram_timing_pkg::*; (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// commands
	input wire sdram_cmd_t  req_cmd,
	input wire logic        req_ack,
	input wire sdram_cmd_t  mem_cmd,
	input wire logic        rd_data_due
);
default clocking cb @(posedge mclk); endclocking
default disable iff (rst);
// shadow of wait control so gaps are judged against the live setting
logic [31:0] wc_ff;
logic [7:0]  since_ff;
sdram_cmd_t  last_ff;
wire logic [1:0] pw = wc_ff[14:13], aw = wc_ff[11:10], cl = wc_ff[8:7], wr = wc_ff[4:3];
wire logic sb = last_ff.bank == mem_cmd.bank;
wire logic act = mem_cmd.op == activate_cmd;
wire logic rdop = mem_cmd.op inside {read_cmd, read_autoprecharge_cmd};
wire logic acc = rdop || mem_cmd.op inside {plain_write_cmd, write_autoprecharge_cmd};
always_ff @(posedge mclk or posedge rst) begin
	if (rst) begin
		wc_ff <= 32'h0000_0500;
		since_ff <= 8'hFF;
		last_ff <= '0;
	end else begin
		if (reg_wr && reg_addr == 8'h00) wc_ff <= reg_wdata;
		since_ff <= since_ff + {7'h0, since_ff != 8'hFF};
		if (mem_cmd.op != cmd_nop) begin
			since_ff <= 8'h01;
			last_ff <= mem_cmd;
		end
	end
end
property p_ack; req_ack |-> mem_cmd == $past(req_cmd) ##1 !req_ack; endproperty
a_ack: assert property (p_ack) else $error("ack mismatch");
property p_rdv; $past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == (wc_ff & 32'h0000_6D98);
endproperty
a_rdv: assert property (p_rdv) else $error("read value");
property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
a_idle: assert property (p_idle) else $error("rdata not idle");
property p_act; acc && last_ff.op == activate_cmd && sb |-> since_ff > aw; endproperty
a_act: assert property (p_act) else $error("activate gap");
property p_pre;
	act && (last_ff.op == precharge_all_cmd || last_ff.op == precharge_cmd && sb) |-> since_ff > pw;
endproperty
a_pre: assert property (p_pre) else $error("precharge gap");
property p_ref;
	mem_cmd.op inside {auto_refresh_cmd, self_refresh_cmd} && last_ff.op == precharge_all_cmd
		|-> since_ff > pw;
endproperty
a_ref: assert property (p_ref) else $error("refresh gap");
property p_wra; act && last_ff.op == write_autoprecharge_cmd && sb |-> since_ff > pw + wr; endproperty
a_wra: assert property (p_wra) else $error("write ap gap");
property p_wrp; mem_cmd.op == precharge_cmd && last_ff.op == plain_write_cmd && sb |-> since_ff > wr;
endproperty
a_wrp: assert property (p_wrp) else $error("write recovery");
property p_cas;
	rdop |-> (if (cl == 2'h0) rd_data_due else if (cl == 2'h1) ##1 rd_data_due else ##2 rd_data_due);
endproperty
a_cas: assert property (p_cas) else $error("cas latency");
c_cas1: cover property (rdop && cl == 2'h0);
c_wra: cover property (act && last_ff.op == write_autoprecharge_cmd);
c_self: cover property (mem_cmd.op == self_refresh_cmd);
endmodule
bind sdram_area3_cmd_timing sdram_area3_cmd_timing_sva u_sdram_area3_cmd_timing_sva (.*);

/* File: verif/sdram_area3_cmd_timing_tb.sv */
// bench: registers, command gaps and read timing of area 3
`timescale 1ns/1ps
module sdram_area3_cmd_timing_tb import sdram_timing_pkg::*;;
typedef struct {sdram_cmd_t c; int gap; int lat;} note_t;
logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
logic        req_ack, rd_data_due, rd_was = 1'b0;
logic [7:0]  reg_addr = 8'h00, faults;
logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'h9CF4, fields;
sdram_cmd_t  req_cmd = '0, mem_cmd;
logic [1:0]  bk = 2'h1;
note_t       q[$], e;
logic [31:0] rq[$];
int          num_errors = 0, total_checks = 0, cyc = 0, last = 0, due = 0, w;
always #10 mclk = ~mclk;
sdram_area3_cmd_timing u_sdram_area3_cmd_timing (.*);
sdram_chip_model u_sdram_chip_model (.*);
////////////////////////////////////////////////////////////////
function automatic logic [31:0] nx(logic [31:0] s);
	return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// the host cannot re-request inside the ack cycle, so no gap is below 2
function automatic int g(int n);
	return (n < 1) ? 2 : n + 1;
endfunction
task automatic check(logic [31:0] got, logic [31:0] exp);
	total_checks++;
	if (got !== exp) begin
		num_errors++;
		$display("ERROR at %0t: saw %h expected %h", $time, got, exp);
	end
endtask
task automatic finish_test();
	$display("checks %0d errors %0d", total_checks, num_errors);
	if (num_errors == 0 && total_checks > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
// a read passes its expected value in d
task automatic reg_acc(logic wr, logic [7:0] a, logic [31:0] d);
	@(posedge mclk);
	reg_addr <= a;
	reg_wdata <= d;
	if (wr) reg_wr <= 1'b1;
	else begin
		reg_rd <= 1'b1;
		rq.push_back(d);
	end
	@(posedge mclk);
	reg_wr <= 1'b0;
	reg_rd <= 1'b0;
endtask
task automatic cmd(sdram_op_t op, int gap, int lat = 0);
	int n = 0;
	q.push_back('{'{op, bk}, gap, lat});
	req_valid <= 1'b1;
	req_cmd <= '{op, bk};
	do @(posedge mclk); while (req_ack !== 1'b1 && ++n < 40);
endtask
always @(posedge mclk) begin
	if (rd_was) check(reg_rdata, rq.pop_front());
	rd_was = reg_rd;
end
always @(posedge mclk) if (!rst) begin
	cyc++;
	if (mem_cmd.op !== cmd_nop) begin
		e = q.pop_front();
		check(32'(mem_cmd), 32'(e.c));
		if (e.gap > 0) check(cyc - last, e.gap);
		last = cyc;
		if (e.lat > 0) due = cyc + e.lat - 1;
	end
	if (rd_data_due === 1'b1) check(cyc, due);
end
initial begin
	repeat (20) @(posedge mclk);
	rst <= 1'b0;
	reg_acc(1'b0, 8'h00, 32'h0000_0500);
	reg_acc(1'b1, 8'h04, 32'hFFFF_FFFF);
	reg_acc(1'b1, 8'h10, 32'h0000_0000);
	reg_acc(1'b0, 8'h04, 32'h0);
	reg_acc(1'b0, 8'h10, 32'h0);
	reg_acc(1'b0, 8'h00, 32'h0000_0500);
	for (int k = 0; k < 4; k++) begin
		lfsr = nx(lfsr);
		w = lfsr[1:0];
		bk = lfsr[3:2];
		fields = {17'h0, 2'(k), 1'b0, 2'(3 - k), 1'b0, 2'(k % 3), 2'h0, lfsr[1:0], 3'h0};
		// stray reserved bits must not stick
		reg_acc(1'b1, 8'h00, fields | (lfsr & 32'hFFFF_9267));
		reg_acc(1'b0, 8'h00, fields);
		cmd(activate_cmd, 0);
		cmd(plain_write_cmd, g(3 - k));
		cmd(precharge_cmd, g(w));
		cmd(activate_cmd, g(k));
		cmd(read_autoprecharge_cmd, g(3 - k), k % 3 + 1);
		cmd(activate_cmd, g(k));
		cmd(write_autoprecharge_cmd, g(3 - k));
		cmd(activate_cmd, g(w + k));
		cmd(read_cmd, g(3 - k), k % 3 + 1);
		cmd(precharge_all_cmd, 2);
		cmd(auto_refresh_cmd, g(k));
		cmd(precharge_all_cmd, 2);
		cmd(self_refresh_cmd, g(k));
		// the status read holds the host off two cycles before the exit
		req_valid <= 1'b0;
		reg_acc(1'b0, 8'h04, 32'h0000_0100);
		cmd(self_refresh_exit_cmd, 4);
		req_valid <= 1'b0;
	end
	repeat (4) @(posedge mclk);
	check(q.size(), 0);
	check(32'(faults), 0);
	finish_test();
end
initial begin
	repeat (5000) @(posedge mclk);
	num_errors++;
	finish_test();
end
endmodule
